// ==== src/bsa_defines.svh ====
// Offsets, field positions, reset values and timing counts for the boot strap block.
`ifndef BSA_DEFINES_SVH
`define BSA_DEFINES_SVH

`define BSA_OFS_START_ADDR 32'h01C4_0008
`define BSA_OFS_BOOT_DONE 32'h01C4_000C
`define BSA_OFS_STRAP_CAP 32'h01C4_0014
`define BSA_OFS_PIN_MUX0 32'h01C4_0004

`define BSA_ROM_BOOT_ADDR 32'h0010_0000
`define BSA_CS2_BOOT_ADDR 32'h4200_0000
`define BSA_ADDR_IGNORE_MASK 32'hFFFF_FC00

`define BSA_PIN_W 12
`define BSA_PIN_BOOT_LSB 0
`define BSA_PIN_QUICK 4
`define BSA_PIN_PLL_LSB 5
`define BSA_PIN_PINOUT_LSB 8
`define BSA_PIN_ENDIAN 11

`define BSA_CAP_BOOT_LSB 0
`define BSA_CAP_PINOUT_LSB 8
`define BSA_CAP_PLL_LSB 12
`define BSA_CAP_QUICK 19
`define BSA_CAP_ENDIAN 20

`define BSA_DONE_BC 0
`define BSA_DONE_ERR_LSB 16
`define BSA_PINMUX_PINOUT_LSB 0

`define BSA_SYNC_STAGES 2
`define BSA_CAPTURE_EDGE 2'h2

`endif

// ==== src/bsa_pkg.sv ====
// Types shared by the boot strap block.
package bsa_pkg;
    typedef enum logic [1:0] {
        BSA_ST_STRAP,
        BSA_ST_HOST_WAIT,
        BSA_ST_RUN
    } bsa_state_t;
endpackage

// ==== src/bsa_strap_if.sv ====
// Latched strap values passed from the capture module to the boot controller.
`timescale 1ns/1ps
`default_nettype none
interface bsa_strap_if;
    logic       valid;
    logic [3:0] boot_select;
    logic       quick_boot_sel;
    logic [2:0] pll_mult_sel;
    logic [2:0] ext_mem_pinout_sel;
    logic       endian_sel;
    modport cap (output valid, boot_select, quick_boot_sel, pll_mult_sel,
                 output ext_mem_pinout_sel, endian_sel);
    modport ctrl (input valid, boot_select, quick_boot_sel, pll_mult_sel,
                  input ext_mem_pinout_sel, endian_sel);
endinterface
`default_nettype wire

// ==== src/bsa_strap_capture.sv ====
// Synchronises the configuration pins and latches them once after reset release.
`timescale 1ns/1ps
`default_nettype none
`include "bsa_defines.svh"
module bsa_strap_capture (
    input wire logic i_clk,                          // Device clock.
    input wire logic i_resetn,                       // Global reset, active low.
    input wire logic [`BSA_PIN_W-1:0] i_cfg_pin,     // Configuration pin levels.
    bsa_strap_if.cap strap                           // Latched strap values.
);
    logic [`BSA_PIN_W-1:0] sync1_r;
    logic [`BSA_PIN_W-1:0] sync2_r;
    logic [1:0] edge_cnt_r;

    // The count covers the synchroniser so that no reset zero is latched.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= i_cfg_pin; // [R18]
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            edge_cnt_r <= 2'h0;
        end else if (edge_cnt_r != `BSA_CAPTURE_EDGE) begin
            edge_cnt_r <= edge_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap.valid <= 1'b0;
            strap.boot_select <= 4'h0;
            strap.quick_boot_sel <= 1'b0;
            strap.pll_mult_sel <= 3'h0;
            strap.ext_mem_pinout_sel <= 3'h0;
            strap.endian_sel <= 1'b0;
        end else if (!strap.valid && edge_cnt_r == `BSA_CAPTURE_EDGE) begin
            strap.valid <= 1'b1; // [R8] [R15] [R18]
            strap.boot_select <= sync2_r[`BSA_PIN_BOOT_LSB +: 4];
            strap.quick_boot_sel <= sync2_r[`BSA_PIN_QUICK];
            strap.pll_mult_sel <= sync2_r[`BSA_PIN_PLL_LSB +: 3];
            strap.ext_mem_pinout_sel <= sync2_r[`BSA_PIN_PINOUT_LSB +: 3];
            strap.endian_sel <= sync2_r[`BSA_PIN_ENDIAN];
        end
    end

    chk_capture_held: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R18]
        strap.valid |=> strap.valid && $stable(strap.boot_select)
            && $stable(strap.ext_mem_pinout_sel))
        else $error("Strap values changed after capture.");
endmodule
`default_nettype wire

// ==== src/bsa_boot_ctrl.sv ====
// Boot strap capture, start address register and host boot handshake.
//
// Notes on behaviour
// R1: On CPU release the fetch address is the current start address register.
// R2: Start address register is 32-bit read/write and reset by global reset.
// R3: Reset default is boot ROM or chip select 2 space, chosen by boot mode.
// R4: Low ten address bits are ignored by the CPU; writers keep them zero.
// R5: Host boot defaults to boot ROM and releases the CPU at once.
// R6: Host writes the start address first, then sets the boot done flag.
// R7: Once boot done is seen, the CPU is redirected to the new start address.
// R8: Boot, quick boot, multiplier, pinout and endian pins latch into a register.
// R9: Configuration pins are straps only in reset, functional pins otherwise.
// R10: Configuration pins stay high impedance until internal reset is removed.
// R11: After release the pins go to GPIO or external memory per latched pinout.
// R12: Latched pinout sets the reset default of the pin mux pinout field.
// R13: External memory power defaults to software reset disabled for pinout zero.
// R14: Latched endian strap selects little endian at one, big endian at zero.
// R15: Straps latch on reset release and their captured fields are read only.
// R16: The multiplier strap is ignored unless quick boot is selected.
// R17: Boot done flag sits at bit zero, zero until the host sets it.
// R18: Straps pass a synchroniser, are sampled once after release, then held.
`timescale 1ns/1ps
`default_nettype none
`include "bsa_defines.svh"
module bsa_boot_ctrl #(
    parameter logic [3:0] HOST_BOOT_MODE = 4'h1,     // Boot select code for host boot.
    parameter logic [3:0] CS2_BOOT_MODE = 4'h2       // Boot select code for chip select 2 boot.
) (
    input wire logic i_clk,                          // Device clock, 200 MHz.
    input wire logic i_resetn,                       // Global reset, active low, async.
    input wire logic i_reg_wr,                       // Register write strobe.
    input wire logic i_reg_rd,                       // Register read strobe.
    input wire logic [31:0] i_reg_addr,              // Register byte address.
    input wire logic [31:0] i_reg_wdata,             // Register write data.
    output logic [31:0] o_reg_rdata,                 // Register read data.
    output logic o_reg_rvalid,                       // Read data valid pulse.
    input wire logic [`BSA_PIN_W-1:0] i_cfg_pin,     // Configuration pin input levels.
    output logic [`BSA_PIN_W-1:0] o_cfg_pin_out,     // Configuration pin drive values.
    output logic [`BSA_PIN_W-1:0] o_cfg_pin_oe,      // Configuration pin enables.
    input wire logic [`BSA_PIN_W-1:0] i_gpio_out,    // GPIO drive values.
    input wire logic [`BSA_PIN_W-1:0] i_gpio_oe,     // GPIO drive enables.
    input wire logic [`BSA_PIN_W-1:0] i_emem_out,    // External memory drive values.
    input wire logic [`BSA_PIN_W-1:0] i_emem_oe,     // External memory drive enables.
    output logic o_cpu_release,                      // CPU out of reset.
    output logic o_cpu_redirect,                     // Pulse: jump to fetch address.
    output logic [31:0] o_cpu_fetch_addr,            // CPU fetch address.
    output logic [2:0] o_pin_mux_pinout,             // Pin mux pinout field.
    output logic o_emem_power_en,                    // External memory enabled.
    output logic o_little_endian,                    // Little endian selected.
    output logic o_quick_boot,                       // Quick boot selected.
    output logic [2:0] o_quick_pll_mult              // Quick boot PLL multiplier.
);
    bsa_strap_if strap ();
    bsa_pkg::bsa_state_t state_r;
    bsa_pkg::bsa_state_t state_nxt;
    logic [31:0] start_addr_r;
    logic host_boot_done_r;
    logic [3:0] boot_err_r;
    logic [2:0] pin_mux_pinout_r;
    logic emem_sel;
    logic wr_start;
    logic wr_done;
    logic wr_pinmux;
    logic [31:0] strap_word;

    function automatic logic [31:0] fetch_of(input logic [31:0] addr);
        fetch_of = addr & `BSA_ADDR_IGNORE_MASK;
    endfunction

    function automatic logic [31:0] default_addr(input logic [3:0] mode);
        default_addr = (mode == CS2_BOOT_MODE) ? `BSA_CS2_BOOT_ADDR : `BSA_ROM_BOOT_ADDR;
    endfunction

    bsa_strap_capture u_capture (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_cfg_pin(i_cfg_pin),
        .strap(strap.cap)
    );

    // Writes before capture are dropped: for start address and pin mux the defaults would overwrite them anyway.
    assign wr_start = i_reg_wr && strap.valid && i_reg_addr == `BSA_OFS_START_ADDR;
    assign wr_done = i_reg_wr && strap.valid && i_reg_addr == `BSA_OFS_BOOT_DONE;
    assign wr_pinmux = i_reg_wr && strap.valid && i_reg_addr == `BSA_OFS_PIN_MUX0;
    assign emem_sel = strap.ext_mem_pinout_sel != 3'h0;

    always_comb begin
        strap_word = 32'h0000_0000;
        strap_word[`BSA_CAP_BOOT_LSB +: 4] = strap.boot_select; // [R8]
        strap_word[`BSA_CAP_PINOUT_LSB +: 3] = strap.ext_mem_pinout_sel;
        strap_word[`BSA_CAP_PLL_LSB +: 3] = strap.pll_mult_sel;
        strap_word[`BSA_CAP_QUICK] = strap.quick_boot_sel;
        strap_word[`BSA_CAP_ENDIAN] = strap.endian_sel;
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bsa_pkg::BSA_ST_STRAP: begin
                if (strap.valid) begin
                    if (strap.boot_select == HOST_BOOT_MODE) begin
                        state_nxt = bsa_pkg::BSA_ST_HOST_WAIT;
                    end else begin
                        state_nxt = bsa_pkg::BSA_ST_RUN;
                    end
                end
            end
            bsa_pkg::BSA_ST_HOST_WAIT: begin
                if (host_boot_done_r) begin
                    state_nxt = bsa_pkg::BSA_ST_RUN; // [R7]
                end
            end
            bsa_pkg::BSA_ST_RUN: begin
                state_nxt = bsa_pkg::BSA_ST_RUN;
            end
            default: begin
                state_nxt = bsa_pkg::BSA_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= bsa_pkg::BSA_ST_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Start address: default loaded when the straps land, then software owned.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_addr_r <= 32'h0000_0000; // [R2]
        end else if (state_r == bsa_pkg::BSA_ST_STRAP && strap.valid) begin
            start_addr_r <= default_addr(strap.boot_select); // [R3] [R5]
        end else if (wr_start) begin
            start_addr_r <= i_reg_wdata; // [R2]
        end
    end

    // Boot done register: both fields are written only by software.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            host_boot_done_r <= 1'b0; // [R17]
            boot_err_r <= 4'h0;
        end else if (wr_done) begin
            host_boot_done_r <= i_reg_wdata[`BSA_DONE_BC]; // [R17]
            boot_err_r <= i_reg_wdata[`BSA_DONE_ERR_LSB +: 4];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_mux_pinout_r <= 3'h0;
        end else if (state_r == bsa_pkg::BSA_ST_STRAP && strap.valid) begin
            pin_mux_pinout_r <= strap.ext_mem_pinout_sel; // [R12]
        end else if (wr_pinmux) begin
            pin_mux_pinout_r <= i_reg_wdata[`BSA_PINMUX_PINOUT_LSB +: 3];
        end
    end

    // CPU control: release at capture, redirect once when the host is done.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cpu_release <= 1'b0;
            o_cpu_redirect <= 1'b0;
            o_cpu_fetch_addr <= 32'h0000_0000;
        end else begin
            o_cpu_redirect <= 1'b0;
            if (state_r == bsa_pkg::BSA_ST_STRAP && strap.valid) begin
                o_cpu_release <= 1'b1; // [R5]
                o_cpu_fetch_addr <= fetch_of(default_addr(strap.boot_select)); // [R1] [R4]
            end else if (state_r == bsa_pkg::BSA_ST_HOST_WAIT && host_boot_done_r) begin
                o_cpu_redirect <= 1'b1; // [R7]
                o_cpu_fetch_addr <= fetch_of(start_addr_r); // [R4] [R6]
            end
        end
    end

    // Pins float until capture; the latched strap, not the pin mux field, picks the owner.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cfg_pin_out <= '0;
            o_cfg_pin_oe <= '0; // [R10]
        end else if (!strap.valid) begin
            o_cfg_pin_out <= '0;
            o_cfg_pin_oe <= '0; // [R9] [R10]
        end else begin
            o_cfg_pin_out <= emem_sel ? i_emem_out : i_gpio_out; // [R11]
            o_cfg_pin_oe <= emem_sel ? i_emem_oe : i_gpio_oe; // [R11]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_emem_power_en <= 1'b0;
            o_little_endian <= 1'b0;
            o_quick_boot <= 1'b0;
            o_quick_pll_mult <= 3'h0;
        end else begin
            o_emem_power_en <= strap.valid && emem_sel; // [R13]
            o_little_endian <= strap.endian_sel; // [R14]
            o_quick_boot <= strap.quick_boot_sel;
            o_quick_pll_mult <= strap.quick_boot_sel ? strap.pll_mult_sel : 3'h0; // [R16]
        end
    end

    assign o_pin_mux_pinout = pin_mux_pinout_r;

    // Read port: one cycle latency, unmapped addresses read zero.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 32'h0000_0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `BSA_OFS_START_ADDR: begin
                        o_reg_rdata <= start_addr_r;
                    end
                    `BSA_OFS_BOOT_DONE: begin
                        o_reg_rdata <= {12'h000, boot_err_r, 15'h0000, host_boot_done_r};
                    end
                    `BSA_OFS_STRAP_CAP: begin
                        o_reg_rdata <= strap_word; // [R15]
                    end
                    `BSA_OFS_PIN_MUX0: begin
                        o_reg_rdata <= {29'h0000_0000, pin_mux_pinout_r};
                    end
                    default: begin
                        o_reg_rdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    chk_pins_float: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
        !strap.valid |=> o_cfg_pin_oe == '0)
        else $error("Configuration pin driven before strap capture.");

    chk_release_fetch: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R1]
        $rose(o_cpu_release) |-> o_cpu_fetch_addr == fetch_of(start_addr_r))
        else $error("CPU released with fetch address unlike start address.");

    chk_low_bits: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R4]
        o_cpu_fetch_addr[9:0] == 10'h000)
        else $error("Fetch address has low bits set.");

    chk_default_addr: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R3]
        $rose(o_cpu_release) |-> start_addr_r == default_addr(strap.boot_select))
        else $error("Start address default does not follow boot mode.");

    chk_host_release: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R5]
        $rose(strap.valid) && strap.boot_select == HOST_BOOT_MODE
            |=> o_cpu_release && start_addr_r == `BSA_ROM_BOOT_ADDR)
        else $error("Host boot not released at the boot ROM.");

    chk_redirect_addr: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R7]
        state_r == bsa_pkg::BSA_ST_HOST_WAIT && host_boot_done_r
            |=> o_cpu_redirect && o_cpu_fetch_addr == fetch_of($past(start_addr_r))
            ##1 !o_cpu_redirect)
        else $error("Redirect missing or at wrong address.");

    chk_pinout_default: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R12]
        $rose(strap.valid) |=> o_pin_mux_pinout == $past(strap.ext_mem_pinout_sel))
        else $error("Pin mux pinout default differs from strap.");

    chk_emem_power: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R13]
        strap.valid && $past(strap.valid) |-> o_emem_power_en == (strap.ext_mem_pinout_sel != 3'h0))
        else $error("External memory power state wrong for pinout.");

    chk_endian_map: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R14]
        strap.valid && $past(strap.valid) |-> o_little_endian == strap.endian_sel)
        else $error("Endian output does not follow strap.");

    chk_pll_ignored: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R16]
        !o_quick_boot |-> o_quick_pll_mult == 3'h0)
        else $error("Multiplier used without quick boot.");

    chk_strap_ro: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
        i_reg_rd && i_reg_addr == `BSA_OFS_STRAP_CAP && strap.valid
            |=> o_reg_rvalid && o_reg_rdata == $past(strap_word))
        else $error("Strap register read back wrong.");

    // The pins are registered, so the owner is judged on the previous cycle's inputs.
    chk_owner_pins: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R11]
        $past(strap.valid) |->
            o_cfg_pin_oe == ($past(emem_sel) ? $past(i_emem_oe) : $past(i_gpio_oe))
            && o_cfg_pin_out == ($past(emem_sel) ? $past(i_emem_out) : $past(i_gpio_out)))
        else $error("Configuration pins not driven by the selected owner.");

    chk_redirect_host: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R7]
        o_cpu_redirect |-> strap.boot_select == HOST_BOOT_MODE
            && $past(state_r) == bsa_pkg::BSA_ST_HOST_WAIT)
        else $error("Redirect outside a host boot wait.");

    chk_start_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
        wr_start && state_r != bsa_pkg::BSA_ST_STRAP |=> start_addr_r == $past(i_reg_wdata))
        else $error("Start address write lost.");

    chk_done_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R17]
        wr_done |=> host_boot_done_r == $past(i_reg_wdata[`BSA_DONE_BC]))
        else $error("Boot done flag does not follow the write.");

    chk_quick_copy: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R16]
        $past(strap.valid) |-> o_quick_boot == strap.quick_boot_sel
            && (!strap.quick_boot_sel || o_quick_pll_mult == strap.pll_mult_sel))
        else $error("Quick boot multiplier not taken from the strap.");
endmodule
`default_nettype wire

// ==== tb/bsa_host_model.sv ====
// Host processor model that drives the register port of the boot block.
`timescale 1ns/1ps
`default_nettype none
`include "bsa_defines.svh"
module bsa_host_model (
    input wire logic i_clk,               // Device clock.
    output logic o_reg_wr,                // Write strobe.
    output logic o_reg_rd,                // Read strobe.
    output logic [31:0] o_reg_addr,       // Register address.
    output logic [31:0] o_reg_wdata,      // Write data.
    input wire logic [31:0] i_reg_rdata,  // Read data.
    input wire logic i_reg_rvalid         // Read data valid.
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 32'h0;
        o_reg_wdata = 32'h0;
    end
    // Released lines flip so a stale address or data word can never pass as valid.
    task automatic idle_bus();
        o_reg_addr = ~o_reg_addr;
        o_reg_wdata = ~o_reg_wdata;
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(negedge i_clk);
        o_reg_addr = addr;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(negedge i_clk);
        o_reg_wr = 1'b0;
        idle_bus();
    endtask
    task automatic rd(input logic [31:0] addr, output logic [31:0] data, output logic ok);
        int n;
        @(negedge i_clk);
        o_reg_addr = addr;
        o_reg_rd = 1'b1;
        @(negedge i_clk);
        o_reg_rd = 1'b0;
        idle_bus();
        ok = 1'b0;
        data = 32'h0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (i_reg_rvalid === 1'b1) begin
                data = i_reg_rdata;
                ok = 1'b1;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask
    // The gap lets the host finish promptly or linger between the two writes.
    task automatic host_boot(input logic [31:0] addr, input int gap);
        wr(`BSA_OFS_START_ADDR, addr & `BSA_ADDR_IGNORE_MASK);
        repeat (gap) @(negedge i_clk);
        wr(`BSA_OFS_BOOT_DONE, 32'h1);
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the boot strap and start address block.
`timescale 1ns/1ps
`default_nettype none
`include "bsa_defines.svh"
module testbench;
    localparam logic [3:0] HOST_MODE = 4'h1;
    localparam logic [3:0] CS2_MODE = 4'h2;
    logic i_clk;
    logic i_resetn;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic [11:0] cfg_pin;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [11:0] gpio_out;
    logic [11:0] gpio_oe;
    logic [11:0] emem_out;
    logic [11:0] emem_oe;
    logic cpu_rel;
    logic redir;
    logic [31:0] fetch;
    logic [2:0] pinmux;
    logic pwr;
    logic lend;
    logic quick;
    logic [2:0] pll;
    logic [31:0] seed;
    logic [31:0] addr;
    logic [31:0] got;
    logic [11:0] pins;
    int errors;
    int comparisons;
    int it;
    int n;
    int hits;
    int hit_at;

    bsa_boot_ctrl #(.HOST_BOOT_MODE(HOST_MODE), .CS2_BOOT_MODE(CS2_MODE)) u_bsa_boot_ctrl (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .o_reg_rvalid(reg_rvalid), .i_cfg_pin(cfg_pin), .o_cfg_pin_out(pin_out),
        .o_cfg_pin_oe(pin_oe), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe),
        .i_emem_out(emem_out), .i_emem_oe(emem_oe), .o_cpu_release(cpu_rel),
        .o_cpu_redirect(redir), .o_cpu_fetch_addr(fetch), .o_pin_mux_pinout(pinmux),
        .o_emem_power_en(pwr), .o_little_endian(lend), .o_quick_boot(quick),
        .o_quick_pll_mult(pll)
    );
    bsa_host_model u_bsa_host_model (
        .i_clk(i_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid)
    );

    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Every mode other than chip select 2 boots from the internal ROM.
    function automatic logic [31:0] exp_start(input logic [3:0] mode);
        return (mode == CS2_MODE) ? `BSA_CS2_BOOT_ADDR : `BSA_ROM_BOOT_ADDR;
    endfunction
    function automatic logic [31:0] exp_cap(input logic [11:0] p);
        logic [31:0] c;
        c = 32'h0;
        c[`BSA_CAP_BOOT_LSB +: 4] = p[`BSA_PIN_BOOT_LSB +: 4];
        c[`BSA_CAP_PINOUT_LSB +: 3] = p[`BSA_PIN_PINOUT_LSB +: 3];
        c[`BSA_CAP_PLL_LSB +: 3] = p[`BSA_PIN_PLL_LSB +: 3];
        c[`BSA_CAP_QUICK] = p[`BSA_PIN_QUICK];
        c[`BSA_CAP_ENDIAN] = p[`BSA_PIN_ENDIAN];
        return c;
    endfunction

    task automatic end_sim();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask
    task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        u_bsa_host_model.rd(a, d, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("read at %08h timed out at %0t", a, $time);
            end_sim();
        end
        check(d, exp);
    endtask

    initial begin
        #500000;
        errors++;
        $display("run limit reached at %0t", $time);
        end_sim();
    end

    initial begin
        i_resetn = 1'b0;
        cfg_pin = 12'h000;
        gpio_out = 12'h000;
        gpio_oe = 12'h000;
        emem_out = 12'h000;
        emem_oe = 12'h000;
        errors = 0;
        comparisons = 0;
        seed = 32'hC47D;
        for (it = 0; it < 6; it++) begin
            seed = lfsr(lfsr(seed));
            pins = seed[11:0];
            pins[3:0] = (it % 3 == 0) ? HOST_MODE : (it % 3 == 1) ? CS2_MODE : seed[15:12];
            if (it < 2) pins[10:8] = 3'h0;
            @(negedge i_clk);
            i_resetn = 1'b0;
            cfg_pin = pins;
            repeat (10) @(negedge i_clk);
            check({20'h0, pin_oe}, 32'h0);
            check({31'h0, cpu_rel}, 32'h0);
            i_resetn = 1'b1;
            for (n = 0; n < 10 && cpu_rel !== 1'b1; n++) @(negedge i_clk);
            check({31'h0, cpu_rel}, 32'h1);
            if (cpu_rel !== 1'b1) end_sim();
            check(fetch, exp_start(pins[3:0]));
            check({29'h0, pinmux}, {29'h0, pins[10:8]});
            check({31'h0, pwr}, {31'h0, pins[10:8] != 3'h0});
            check({31'h0, lend}, {31'h0, pins[11]});
            check({28'h0, quick, pll}, {28'h0, pins[4], pins[4] ? pins[7:5] : 3'h0});
            cfg_pin = ~pins;
            repeat (4) begin
                seed = lfsr(seed);
                {gpio_oe, gpio_out} = seed[23:0];
                seed = lfsr(seed);
                {emem_oe, emem_out} = seed[31:8];
                @(negedge i_clk);
                check({8'h0, pin_oe, pin_out},
                      {8'h0, (pins[10:8] != 3'h0) ? {emem_oe, emem_out} : {gpio_oe, gpio_out}});
            end
            rd_check(`BSA_OFS_STRAP_CAP, exp_cap(pins));
            u_bsa_host_model.wr(`BSA_OFS_STRAP_CAP, 32'hFFFF_FFFF);
            rd_check(`BSA_OFS_STRAP_CAP, exp_cap(pins));
            rd_check(`BSA_OFS_START_ADDR, exp_start(pins[3:0]));
            rd_check(`BSA_OFS_BOOT_DONE, 32'h0);
            rd_check(`BSA_OFS_START_ADDR + 32'h8, 32'h0);
            u_bsa_host_model.wr(`BSA_OFS_PIN_MUX0, {29'h0, ~pins[10:8]});
            rd_check(`BSA_OFS_PIN_MUX0, {29'h0, ~pins[10:8]});
            check({31'h0, pwr}, {31'h0, pins[10:8] != 3'h0});
            seed = lfsr(seed);
            addr = seed & `BSA_ADDR_IGNORE_MASK;
            u_bsa_host_model.host_boot(addr, it % 3);
            hits = 0;
            hit_at = 0;
            got = 32'h0;
            for (n = 0; n < 8; n++) begin
                @(negedge i_clk);
                if (redir === 1'b1) begin
                    hits++;
                    hit_at = n;
                    got = fetch;
                end
            end
            if (pins[3:0] == HOST_MODE) begin
                check(32'(hits), 32'h1);
                check(32'(hit_at), 32'h0);
                check(got, addr);
            end else begin
                check(32'(hits), 32'h0);
            end
            check(fetch, (pins[3:0] == HOST_MODE) ? addr : exp_start(pins[3:0]));
            rd_check(`BSA_OFS_START_ADDR, addr);
            rd_check(`BSA_OFS_BOOT_DONE, 32'h1);
            $display("test %0d done", it);
        end
        end_sim();
    end
endmodule
`default_nettype wire
